// [ppm_defines.svh]
// Offsets, field positions, fixed values and reset values of the power-management capability
// Summary of operation
// - Read-only five-bit wake-source support field, D3cold..D0
// - Wake-source support reads fixed 0x09
// - State2 supported bit reads zero
// - State1 supported bit reads zero
// - Special-initialization bit reads zero
// - Wake-needs-clock bit reads zero
// - Interface version field reads 0x2
// - Local wake request sets wake event status
// - Host writing one clears wake status
// - Wake pin driven only when enabled
// - Host setting enable raises enable-set flag
// - Two-bit power state field, resets D0
// - Power state change raises change flag
// - Power state mirrored to local side
// - Host reaches registers only in satellite mode
`ifndef PPM_DEFINES_SVH
`define PPM_DEFINES_SVH
`define PPM_CAP_OFFSET 8'hDE
`define PPM_CSR_OFFSET 8'hE0
`define PPM_CAP_INDEX 6'h37
`define PPM_CSR_INDEX 6'h38
`define PPM_WSRC_VAL 5'h09
`define PPM_VER_VAL 3'h2
`define PPM_STAT_BIT 15
`define PPM_EN_BIT 8
`define PPM_PS_MSB 1
`define PPM_PS_RESET 2'h0
`endif

// [ppm_pkg.sv]
// Types of the power-management capability
package ppm_pkg;
   typedef enum logic [1:0] {
      PPM_D0 = 2'h0,
      PPM_D1 = 2'h1,
      PPM_D3HOT = 2'h3,
      PPM_D2 = 2'h2
   } ppm_pstate_t;
endpackage : ppm_pkg

// [ppm_cfg_decode.sv]
// Configuration-cycle address and byte-lane decode
`timescale 1ns/1ps
`include "ppm_defines.svh"
module ppm_cfg_decode (
   input wire logic satellite_mode,
   input wire logic cfg_rd,
   input wire logic cfg_wr,
   input wire logic [5:0] cfg_index,
   input wire logic [3:0] cfg_be,
   output logic cap_sel,
   output logic csr_sel,
   output logic rd_take,
   output logic wr_hi,
   output logic wr_lo
);
   always_comb begin
      cap_sel = (cfg_index == `PPM_CAP_INDEX);
      csr_sel = (cfg_index == `PPM_CSR_INDEX);
      rd_take = cfg_rd & satellite_mode;
      wr_hi = cfg_wr & satellite_mode & csr_sel & cfg_be[1];
      wr_lo = cfg_wr & satellite_mode & csr_sel & cfg_be[0];
   end
endmodule : ppm_cfg_decode

// [ppm_csr_ctrl.sv]
// Control/status word state and its local events
`timescale 1ns/1ps
`include "ppm_defines.svh"
module ppm_csr_ctrl (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic wr_hi,
   input wire logic wr_lo,
   input wire logic [15:0] wdata,
   input wire logic local_wake_request,
   output logic wake_event_status_reg,
   output logic wake_enable_reg,
   output ppm_pkg::ppm_pstate_t power_state_field_reg,
   output logic enable_set_evt,
   output logic ps_change_evt,
   output logic wake_clear_evt
);
   logic clear_req;

   always_comb begin
      clear_req = wr_hi & wdata[`PPM_STAT_BIT];
      wake_clear_evt = clear_req & wake_event_status_reg & ~local_wake_request;
      enable_set_evt = wr_hi & wdata[`PPM_EN_BIT] & ~wake_enable_reg;
      ps_change_evt = wr_lo & (wdata[`PPM_PS_MSB:0] != power_state_field_reg);
   end

   // Set wins over a simultaneous clear
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         wake_event_status_reg <= 1'b0;
      end else begin
         wake_event_status_reg <= local_wake_request | (wake_event_status_reg & ~clear_req);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         wake_enable_reg <= 1'b0;
      end else if (wr_hi) begin
         wake_enable_reg <= wdata[`PPM_EN_BIT];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         power_state_field_reg <= ppm_pkg::ppm_pstate_t'(`PPM_PS_RESET);
      end else if (wr_lo) begin
         power_state_field_reg <= ppm_pkg::ppm_pstate_t'(wdata[`PPM_PS_MSB:0]);
      end
   end
endmodule : ppm_csr_ctrl

// [ppm_capability.sv]
// Power-management capability and control/status words seen by configuration cycles
`timescale 1ns/1ps
`include "ppm_defines.svh"
module ppm_capability (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic satellite_mode,
   input wire logic cfg_rd,
   input wire logic cfg_wr,
   input wire logic [5:0] cfg_index,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata_reg,
   output logic cfg_rvalid_reg,
   input wire logic local_wake_request,
   output logic wake_enable_set_flag_reg,
   output logic power_state_change_flag_reg,
   output logic wake_clear_flag_reg,
   output logic [1:0] local_power_state_mirror_reg,
   output logic wake_pin_o_reg,
   output logic wake_pin_oe_reg
);
   logic cap_sel;
   logic csr_sel;
   logic rd_take;
   logic wr_hi;
   logic wr_lo;
   logic wake_event_status;
   logic wake_enable;
   ppm_pkg::ppm_pstate_t power_state_field;
   logic enable_set_evt;
   logic ps_change_evt;
   logic wake_clear_evt;
   logic [15:0] power_capability_word;
   logic [15:0] power_control_status_word;
   logic [31:0] rd_next;

   ppm_cfg_decode u_decode (
      .satellite_mode(satellite_mode),
      .cfg_rd(cfg_rd),
      .cfg_wr(cfg_wr),
      .cfg_index(cfg_index),
      .cfg_be(cfg_be),
      .cap_sel(cap_sel),
      .csr_sel(csr_sel),
      .rd_take(rd_take),
      .wr_hi(wr_hi),
      .wr_lo(wr_lo)
   );

   ppm_csr_ctrl u_csr (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .wr_hi(wr_hi),
      .wr_lo(wr_lo),
      .wdata(cfg_wdata[15:0]),
      .local_wake_request(local_wake_request),
      .wake_event_status_reg(wake_event_status),
      .wake_enable_reg(wake_enable),
      .power_state_field_reg(power_state_field),
      .enable_set_evt(enable_set_evt),
      .ps_change_evt(ps_change_evt),
      .wake_clear_evt(wake_clear_evt)
   );

   // Capability word: constant fields only, reserved positions zero
   always_comb begin
      power_capability_word = {
         `PPM_WSRC_VAL,
         1'b0,
         1'b0,
         3'h0,
         1'b0,
         1'b0,
         1'b0,
         `PPM_VER_VAL
      };
   end

   // Control/status word with reserved bits zero
   always_comb begin
      power_control_status_word = {
         wake_event_status,
         6'h00,
         wake_enable,
         6'h00,
         power_state_field
      };
   end

   // Capability sits in the upper lanes, control/status in the lower lanes
   always_comb begin
      rd_next = 32'h0000_0000;
      if (cap_sel) begin
         rd_next = {power_capability_word, 16'h0000};
      end else if (csr_sel) begin
         rd_next = {16'h0000, power_control_status_word};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         cfg_rdata_reg <= 32'h0000_0000;
         cfg_rvalid_reg <= 1'b0;
      end else begin
         cfg_rvalid_reg <= rd_take;
         if (rd_take) begin
            cfg_rdata_reg <= rd_next;
         end
      end
   end

   // Local event pulses, one cycle each
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         wake_enable_set_flag_reg <= 1'b0;
         power_state_change_flag_reg <= 1'b0;
         wake_clear_flag_reg <= 1'b0;
      end else begin
         wake_enable_set_flag_reg <= enable_set_evt;
         power_state_change_flag_reg <= ps_change_evt;
         wake_clear_flag_reg <= wake_clear_evt;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         local_power_state_mirror_reg <= `PPM_PS_RESET;
      end else begin
         local_power_state_mirror_reg <= power_state_field;
      end
   end

   // Open-drain wake pin: low level, driven only while enabled
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         wake_pin_o_reg <= 1'b0;
         wake_pin_oe_reg <= 1'b0;
      end else begin
         wake_pin_o_reg <= 1'b0;
         wake_pin_oe_reg <= wake_event_status & wake_enable;
      end
   end

   wake_src_ro_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      (cfg_wr && cap_sel) ##[1:2] (cfg_rd && satellite_mode && cap_sel)
      |=> cfg_rdata_reg[31:27] == `PPM_WSRC_VAL)
      else $error("wake source field changed by a write");

   wake_src_val_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rd_take && cap_sel |=> cfg_rvalid_reg && cfg_rdata_reg[31:27] == `PPM_WSRC_VAL)
      else $error("wake source field wrong");

   state2_zero_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rd_take && cap_sel |=> !cfg_rdata_reg[26])
      else $error("state2 support bit set");

   state1_zero_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rd_take && cap_sel |=> !cfg_rdata_reg[25])
      else $error("state1 support bit set");

   spec_init_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rd_take && cap_sel |=> !cfg_rdata_reg[21])
      else $error("special init bit set");

   wake_clock_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rd_take && cap_sel |=> !cfg_rdata_reg[19])
      else $error("wake clock bit set");

   version_val_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rd_take && cap_sel |=> cfg_rdata_reg[18:16] == `PPM_VER_VAL)
      else $error("interface version wrong");

   wake_set_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      local_wake_request |=> wake_event_status)
      else $error("wake request did not set status");

   wake_clear_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      wr_hi && cfg_wdata[`PPM_STAT_BIT] && !local_wake_request
      |=> !wake_event_status && ($past(wake_event_status) == wake_clear_flag_reg))
      else $error("write one did not clear status");

   wake_keep_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      wake_event_status && !(wr_hi && cfg_wdata[`PPM_STAT_BIT]) |=> wake_event_status)
      else $error("status lost without a clear");

   wake_block_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !wake_enable |=> !wake_pin_oe_reg)
      else $error("wake pin driven while disabled");

   enable_flag_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      $rose(wake_enable) |-> wake_enable_set_flag_reg ##1 !wake_enable_set_flag_reg)
      else $error("enable set flag missing");

   pstate_store_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      wr_lo |=> power_state_field == $past(cfg_wdata[1:0]))
      else $error("power state not stored");

   pstate_flag_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      $past(resetn) && $changed(power_state_field) |-> power_state_change_flag_reg)
      else $error("power state change flag missing");

   mirror_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      ##1 local_power_state_mirror_reg == $past(power_state_field))
      else $error("mirror does not follow power state");

   satellite_only_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !satellite_mode |=> !cfg_rvalid_reg && $stable(wake_enable) && $stable(power_state_field))
      else $error("access outside satellite mode");

   wake_drive_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      wake_event_status && wake_enable |=> wake_pin_oe_reg && !wake_pin_o_reg)
      else $error("wake pin not driven");

   reserved_zero_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rd_take && csr_sel |=> cfg_rdata_reg[31:16] == 16'h0000
      && cfg_rdata_reg[14:9] == 6'h00 && cfg_rdata_reg[7:2] == 6'h00)
      else $error("reserved control bits not zero");

   reserved_cap_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rd_take && cap_sel |=> cfg_rdata_reg[15:0] == 16'h0000
      && cfg_rdata_reg[24:22] == 3'h0 && !cfg_rdata_reg[20])
      else $error("reserved capability bits not zero");

   wake_release_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !wake_event_status |=> !wake_pin_oe_reg)
      else $error("wake pin driven without status");

   set_wins_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      local_wake_request && wr_hi && cfg_wdata[`PPM_STAT_BIT] |=> wake_event_status && !wake_clear_flag_reg)
      else $error("clear beat a simultaneous wake request");

   clear_flag_only_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      wake_clear_flag_reg |-> $fell(wake_event_status))
      else $error("wake clear flag without a clear");

   enable_store_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      wr_hi |=> wake_enable == $past(cfg_wdata[`PPM_EN_BIT]))
      else $error("wake enable not stored");

   enable_hold_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !wr_hi |=> $stable(wake_enable))
      else $error("wake enable changed without a write");

   enable_flag_only_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      wake_enable_set_flag_reg |-> wake_enable && !$past(wake_enable))
      else $error("enable set flag without a rise");

   pstate_hold_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !wr_lo |=> $stable(power_state_field))
      else $error("power state changed without a write");

   pstate_flag_only_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      power_state_change_flag_reg |-> $changed(power_state_field))
      else $error("power state flag without a change");

   rvalid_pulse_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      rd_take |=> cfg_rvalid_reg)
      else $error("read answer missing");

   rvalid_idle_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !rd_take |=> !cfg_rvalid_reg)
      else $error("read answer without a read");

   rdata_hold_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !rd_take |=> $stable(cfg_rdata_reg))
      else $error("read data changed without a read");

   access_gate_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      !satellite_mode |-> !wr_hi && !wr_lo && !rd_take)
      else $error("access decoded outside satellite mode");

   cap_write_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      cfg_wr && cap_sel |-> !wr_hi && !wr_lo)
      else $error("capability write reached control state");

   csr_write_a: assert property (
      @(posedge sys_clk) disable iff (!resetn)
      wr_hi || wr_lo |-> csr_sel)
      else $error("write decoded outside control word");
endmodule : ppm_capability

// [ppm_host_model.sv]
// Host bridge model issuing configuration cycles
`timescale 1ns/1ps
module ppm_host_model (
   input wire logic sys_clk,
   input wire logic [31:0] cfg_rdata_reg,
   input wire logic cfg_rvalid_reg,
   output logic cfg_rd,
   output logic cfg_wr,
   output logic [5:0] cfg_index,
   output logic [3:0] cfg_be,
   output logic [31:0] cfg_wdata
);
   initial begin
      cfg_rd = 1'b0;
      cfg_wr = 1'b0;
      cfg_index = 6'h00;
      cfg_be = 4'h0;
      cfg_wdata = 32'h0000_0000;
   end
   // One write pulse; a one in bit 15 clears wake status
   task cfg_write(input logic [5:0] idx, input logic [3:0] be, input logic [31:0] d);
      @(posedge sys_clk);
      #1;
      cfg_wr = 1'b1;
      cfg_index = idx;
      cfg_be = be;
      cfg_wdata = d;
      @(posedge sys_clk);
      #1;
      cfg_wr = 1'b0;
      cfg_index = ~idx;
      cfg_wdata = ~d;
   endtask : cfg_write
   // One read pulse; answer sampled in the following cycle
   task cfg_read(input logic [5:0] idx, output logic [31:0] d, output logic ok);
      @(posedge sys_clk);
      #1;
      cfg_rd = 1'b1;
      cfg_index = idx;
      @(posedge sys_clk);
      #1;
      cfg_rd = 1'b0;
      cfg_index = ~idx;
      d = cfg_rdata_reg;
      ok = cfg_rvalid_reg;
   endtask : cfg_read
endmodule : ppm_host_model

// [testbench.sv]
// Self-checking bench of the power-management capability
`timescale 1ns/1ps
module testbench;
   typedef struct {logic [5:0] wi; logic [3:0] be; logic [31:0] wd; logic [5:0] ri; logic [31:0] ex;} ppm_row_t;
   logic sys_clk, resetn, satellite_mode, local_wake_request, cfg_rd, cfg_wr, cfg_rvalid_reg, ok;
   logic wake_enable_set_flag_reg, power_state_change_flag_reg, wake_clear_flag_reg, wake_pin_o_reg, wake_pin_oe_reg;
   logic [5:0] cfg_index;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata_reg, rd;
   logic [1:0] local_power_state_mirror_reg;
   int n_mismatch, compares, cyc;
   ppm_row_t rows [7];
   ppm_capability dut_u (.sys_clk(sys_clk), .resetn(resetn), .satellite_mode(satellite_mode), .cfg_rd(cfg_rd),
      .cfg_wr(cfg_wr), .cfg_index(cfg_index), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata_reg(cfg_rdata_reg),
      .cfg_rvalid_reg(cfg_rvalid_reg), .local_wake_request(local_wake_request),
      .wake_enable_set_flag_reg(wake_enable_set_flag_reg), .power_state_change_flag_reg(power_state_change_flag_reg),
      .wake_clear_flag_reg(wake_clear_flag_reg), .local_power_state_mirror_reg(local_power_state_mirror_reg),
      .wake_pin_o_reg(wake_pin_o_reg), .wake_pin_oe_reg(wake_pin_oe_reg));
   ppm_host_model host_u (.sys_clk(sys_clk), .cfg_rdata_reg(cfg_rdata_reg), .cfg_rvalid_reg(cfg_rvalid_reg),
      .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_index(cfg_index), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task test_done;
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done
   task wake_pulse;
      @(posedge sys_clk);
      #1;
      local_wake_request = 1'b1;
      @(posedge sys_clk);
      #1;
      local_wake_request = 1'b0;
   endtask : wake_pulse
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         test_done;
      end
   end
   initial begin
      resetn = 1'b0;
      satellite_mode = 1'b1;
      local_wake_request = 1'b0;
      rows[0] = '{6'h38, 4'h3, 32'h0000_0103, 6'h38, 32'h0000_0103};
      rows[1] = '{6'h38, 4'hF, 32'hFFFF_7EFE, 6'h38, 32'h0000_0002};
      rows[2] = '{6'h38, 4'h1, 32'h0000_0101, 6'h38, 32'h0000_0001};
      rows[3] = '{6'h38, 4'h2, 32'h0000_0100, 6'h38, 32'h0000_0101};
      rows[4] = '{6'h37, 4'hF, 32'hFFFF_FFFF, 6'h37, 32'h4802_0000};
      rows[5] = '{6'h10, 4'hF, 32'hFFFF_FFFF, 6'h10, 32'h0000_0000};
      rows[6] = '{6'h38, 4'h3, 32'h0000_0000, 6'h38, 32'h0000_0000};
      repeat (8) @(posedge sys_clk);
      #1;
      resetn = 1'b1;
      @(posedge sys_clk);
      // Reset state
      host_u.cfg_read(6'h38, rd, ok);
      chk(rd, 32'h0000_0000);
      chk({30'h0, local_power_state_mirror_reg}, 32'h0000_0000);
      chk({31'h0, wake_pin_oe_reg}, 32'h0000_0000);
      // Table of writes and readbacks
      foreach (rows[i]) begin
         host_u.cfg_write(rows[i].wi, rows[i].be, rows[i].wd);
         host_u.cfg_read(rows[i].ri, rd, ok);
         chk({ok, rd[30:0]}, {1'b1, rows[i].ex[30:0]});
         chk({31'h0, rd[31]}, {31'h0, rows[i].ex[31]});
      end
      // Enable and power state change events
      host_u.cfg_write(6'h38, 4'h3, 32'h0000_0103);
      chk({31'h0, wake_enable_set_flag_reg}, 32'h0000_0001);
      chk({31'h0, power_state_change_flag_reg}, 32'h0000_0001);
      @(posedge sys_clk);
      #1;
      chk({30'h0, local_power_state_mirror_reg}, 32'h0000_0003);
      chk({30'h0, wake_enable_set_flag_reg, power_state_change_flag_reg}, 32'h0000_0000);
      host_u.cfg_write(6'h38, 4'h3, 32'h0000_0103);
      chk({30'h0, wake_enable_set_flag_reg, power_state_change_flag_reg}, 32'h0000_0000);
      // Local wake request drives the pin
      wake_pulse;
      @(posedge sys_clk);
      #1;
      chk({30'h0, wake_pin_oe_reg, wake_pin_o_reg}, 32'h0000_0002);
      host_u.cfg_read(6'h38, rd, ok);
      chk(rd, 32'h0000_8103);
      host_u.cfg_write(6'h38, 4'h2, 32'h0000_0100);
      host_u.cfg_read(6'h38, rd, ok);
      chk(rd, 32'h0000_8103);
      host_u.cfg_write(6'h38, 4'h2, 32'h0000_8100);
      chk({31'h0, wake_clear_flag_reg}, 32'h0000_0001);
      @(posedge sys_clk);
      #1;
      chk({31'h0, wake_pin_oe_reg}, 32'h0000_0000);
      // Wake blocked while disabled
      host_u.cfg_write(6'h38, 4'h2, 32'h0000_0000);
      wake_pulse;
      repeat (3) @(posedge sys_clk);
      #1;
      chk({31'h0, wake_pin_oe_reg}, 32'h0000_0000);
      host_u.cfg_read(6'h38, rd, ok);
      chk(rd, 32'h0000_8003);
      // Accesses outside satellite mode are ignored
      satellite_mode = 1'b0;
      host_u.cfg_write(6'h38, 4'h3, 32'h0000_8100);
      host_u.cfg_read(6'h38, rd, ok);
      chk({31'h0, ok}, 32'h0000_0000);
      satellite_mode = 1'b1;
      host_u.cfg_read(6'h38, rd, ok);
      chk(rd, 32'h0000_8003);
      // Local request in the same cycle as a host clear: the set wins
      fork
         host_u.cfg_write(6'h38, 4'h2, 32'h0000_8000);
         wake_pulse;
      join
      chk({31'h0, wake_clear_flag_reg}, 32'h0000_0000);
      host_u.cfg_read(6'h38, rd, ok);
      chk(rd, 32'h0000_8003);
      host_u.cfg_write(6'h38, 4'h2, 32'h0000_0100);
      @(posedge sys_clk);
      #1;
      chk({31'h0, wake_pin_oe_reg}, 32'h0000_0001);
      // Reset in mid-run returns outputs and state to idle
      @(posedge sys_clk);
      #1;
      resetn = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      resetn = 1'b1;
      chk({29'h0, wake_pin_oe_reg, local_power_state_mirror_reg}, 32'h0000_0000);
      chk({30'h0, wake_enable_set_flag_reg, power_state_change_flag_reg}, 32'h0000_0000);
      @(posedge sys_clk);
      host_u.cfg_read(6'h38, rd, ok);
      chk(rd, 32'h0000_0000);
      test_done;
   end
endmodule : testbench
